// >>> design/odd_div_pkg.sv
// shared constants and types for the selectable odd clock divider
package odd_div_pkg;

  // ---------------------------------------------------------------
  // division ratios and counter
  // ---------------------------------------------------------------
  localparam int         RATIO_LO_DEF = 3;      // ratio with select low
  localparam int         RATIO_HI_DEF = 5;      // ratio with select high
  localparam int         CNT_W_DEF    = 3;      // half-period counter width
  localparam logic [2:0] CNT_RST      = 3'h0;   // counter start phase

  // ---------------------------------------------------------------
  // reset values: control pins read high when left open; the clock
  // filter starts low like an idle source, so reset makes no false edge
  // ---------------------------------------------------------------
  localparam logic [3:0] PINS_RST     = 4'h7;   // in_clk 0, enable 1, clear_n 1, sel 1
  localparam logic       DIV_RST      = 1'b0;
  localparam logic       EN_RST       = 1'b1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    DIV_BY_LO,
    DIV_BY_HI
  } ratio_t;

  typedef struct packed {
    logic in_clk;       // incoming clock to be divided
    logic enable;       // output enable, high = run
    logic clear_n;      // clear, active low
    logic ratio_sel;    // low = lo ratio, high = hi ratio
  } pins_t;

  typedef struct packed {
    pins_t      filt;    // filtered pin levels
    logic [2:0] cnt;     // half-period edge counter
    logic       div;     // free-running divided clock
    logic       en_req;  // enable taken at an input rising edge
    logic       en_on;   // enable applied at an input falling edge
    ratio_t     ratio;   // ratio in use for this output period
  } state_t;

endpackage

// >>> design/pin_sync3.sv
// three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // pins in, second and third stage out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] stage2,
  output logic      [W-1:0] stage3
);

  logic [W-1:0] stage1_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1_q <= RST_VAL;
      stage2   <= RST_VAL;
      stage3   <= RST_VAL;
    end else begin
      stage1_q <= pin_in;
      stage2   <= stage1_q;
      stage3   <= stage2;
    end
  end

endmodule

`default_nettype wire

// >>> design/selectable_odd_clock_divider.sv
// selectable odd-ratio clock divider with synchronous enable and a clear that also gates the output directly from its pin
`timescale 1ns/1ps
`default_nettype none

module selectable_odd_clock_divider
  import odd_div_pkg::*;
#(
  parameter int RATIO_LO = RATIO_LO_DEF,
  parameter int RATIO_HI = RATIO_HI_DEF,
  parameter int CNT_W    = CNT_W_DEF
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // pins from outside the clock domain
  input  wire logic in_clk,
  input  wire logic enable,
  input  wire logic async_clear_n,
  input  wire logic ratio_sel,
  // complementary divided output
  output logic      out_clk,
  output logic      out_clk_n
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the counter is three bits wide, so each ratio must be odd for an even
  // split of input edges and at most 7 to fit
  if (CNT_W != 3) begin : g_bad_width
    $error("counter width must be 3");
  end
  if (RATIO_LO < 3 || RATIO_LO > 7 || RATIO_LO % 2 == 0) begin : g_bad_lo
    $error("low ratio must be odd and within 3..7");
  end
  if (RATIO_HI < 3 || RATIO_HI > 7 || RATIO_HI % 2 == 0) begin : g_bad_hi
    $error("high ratio must be odd and within 3..7");
  end

  localparam logic [2:0] LIM_LO = 3'(RATIO_LO - 1);
  localparam logic [2:0] LIM_HI = 3'(RATIO_HI - 1);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  pins_t  pins_raw;
  pins_t  pins_s2;
  pins_t  pins_s3;
  state_t st_q;
  state_t st_d;
  logic   rise_ev;
  logic   fall_ev;
  logic   [2:0] lim;

  assign pins_raw = '{in_clk: in_clk, enable: enable, clear_n: async_clear_n,
                      ratio_sel: ratio_sel};

  // in_clk goes through the same filter as the control pins; it must hold
  // each level for at least two clocks or an edge is lost
  pin_sync3 #(
    .W       (4),
    .RST_VAL (PINS_RST)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin_in  (pins_raw),
    .stage2  (pins_s2),
    .stage3  (pins_s3)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // every input edge counts, so each half of the output lasts exactly
  // the ratio in input half-periods: 50 percent duty for odd ratios
  always_comb begin
    st_d = st_q;
    // a filtered bit moves only once stages two and three agree
    st_d.filt = (~(pins_s2 ^ pins_s3) & pins_s3) | ((pins_s2 ^ pins_s3) & st_q.filt);
    rise_ev = st_d.filt.in_clk & ~st_q.filt.in_clk;
    fall_ev = ~st_d.filt.in_clk & st_q.filt.in_clk;
    lim = (st_q.ratio == DIV_BY_HI) ? LIM_HI : LIM_LO;
    if (!st_d.filt.clear_n) begin
      st_d.cnt   = CNT_RST;
      st_d.div   = DIV_RST;
      // under clear the enable pin applies at once: there is no pulse to protect
      st_d.en_on = st_d.filt.enable;
      st_d.en_req = st_d.filt.enable;
      st_d.ratio = st_d.filt.ratio_sel ? DIV_BY_HI : DIV_BY_LO;
    end else if (rise_ev || fall_ev) begin
      if (st_q.cnt == lim) begin
        st_d.cnt = CNT_RST;
        st_d.div = ~st_q.div;
        // ratio changes only at the start of a low half, no short pulse
        if (st_q.div)
          st_d.ratio = st_d.filt.ratio_sel ? DIV_BY_HI : DIV_BY_LO;
      end else begin
        st_d.cnt = st_q.cnt + 3'h1;
      end
      if (rise_ev)
        st_d.en_req = st_d.filt.enable;
      // applied only while the divided clock is low, so no pulse is cut
      if (fall_ev && !st_d.div)
        st_d.en_on = st_q.en_req;
    end
  end

  // state register; high pin defaults come from the reset values
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q.filt   <= PINS_RST;
      st_q.cnt    <= CNT_RST;
      st_q.div    <= DIV_RST;
      st_q.en_req <= EN_RST;
      st_q.en_on  <= EN_RST;
      st_q.ratio  <= DIV_BY_HI;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the raw clear pin gates the output so it acts without waiting for
  // the synchroniser; trade-off: this one term is not from a flip-flop
  assign out_clk   = st_q.div & st_q.en_on & async_clear_n;
  assign out_clk_n = ~out_clk;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_wrap;
    (rise_ev || fall_ev) && st_q.filt.clear_n && st_d.filt.clear_n && st_q.cnt == lim;
  endsequence

  // a counted edge that does not end a half
  sequence s_step;
    (rise_ev || fall_ev) && st_q.filt.clear_n && st_d.filt.clear_n && st_q.cnt != lim;
  endsequence

  // no counted edge and no clear: neither the counter nor the divided clock may move
  sequence s_idle;
    !(rise_ev || fall_ev) && st_q.filt.clear_n && st_d.filt.clear_n;
  endsequence

  // the clear is watched on the raw pin, since the output gate uses it
  a_clear_forces_out: assert property (
    !async_clear_n |-> (!out_clk && out_clk_n))
    else $error("clear did not force outputs");

  a_disabled_holds_low: assert property (
    !st_q.en_on |-> (!out_clk && out_clk_n))
    else $error("disabled output not held low");

  a_enable_at_fall: assert property (
    $changed(st_q.en_on) && $past(st_d.filt.clear_n) |-> $past(fall_ev) && !st_q.div)
    else $error("enable applied away from a falling edge");

  a_count_in_range: assert property (
    st_q.cnt <= ((st_q.ratio == DIV_BY_HI) ? LIM_HI : LIM_LO))
    else $error("counter beyond ratio");

  // a toggle only follows the last count of a half, so every half holds
  // exactly the ratio in input edges, which keeps the duty at one half
  a_div3_toggle: assert property (
    $changed(st_q.div) && $past(st_q.ratio) == DIV_BY_LO && $past(st_d.filt.clear_n)
      |-> $past(st_q.cnt) == 3'h2)
    else $error("divide by three toggled off phase");

  a_div5_toggle: assert property (
    $changed(st_q.div) && $past(st_q.ratio) == DIV_BY_HI && $past(st_d.filt.clear_n)
      |-> $past(st_q.cnt) == 3'h4)
    else $error("divide by five toggled off phase");

  a_wrap_toggles: assert property (
    s_wrap |=> $changed(st_q.div) && st_q.cnt == CNT_RST)
    else $error("wrap did not toggle divided clock");

  a_clear_start_phase: assert property (
    !st_q.filt.clear_n ##1 !st_q.filt.clear_n |-> st_q.cnt == CNT_RST && !st_q.div)
    else $error("counter not at start phase under clear");

  a_open_defaults: assert property (
    $fell(sys_rst) |-> st_q.filt == PINS_RST && st_q.en_on && st_q.ratio == DIV_BY_HI)
    else $error("defaults after reset not high");

  // one step per counted edge, never more
  a_count_steps: assert property (
    s_step |=> st_q.cnt == $past(st_q.cnt) + 3'h1 && $stable(st_q.div))
    else $error("counter did not step on an input edge");

  a_idle_holds: assert property (
    s_idle |=> $stable(st_q.cnt) && $stable(st_q.div))
    else $error("divider moved without an input edge");

  a_ratio_at_fall: assert property (
    $changed(st_q.ratio) && $past(st_d.filt.clear_n) |-> $fell(st_q.div))
    else $error("ratio changed away from the end of a high half");

  // enable is sampled on rising edges only and applied on falling ones
  a_req_at_rise: assert property (
    $changed(st_q.en_req) && $past(st_d.filt.clear_n) |-> $past(rise_ev))
    else $error("enable request taken away from a rising edge");

  a_high_not_cut: assert property (
    $past(st_q.div && st_q.en_on && st_d.filt.clear_n) && st_q.div |-> st_q.en_on)
    else $error("enable removed inside a high half");

endmodule

`default_nettype wire

// >>> testbench/in_clk_src.sv
// clock source model that drives the divider's incoming clock
`timescale 1ns/1ps
`default_nettype none

module in_clk_src #(
  parameter int HALF = 8
) (
  // system clock and run control
  input  wire logic clock,
  input  wire logic run,
  // generated clock
  output logic      in_clk
);
  int   cnt   = 0;
  logic lvl_q = 1'b0;
  assign in_clk = lvl_q;
  // a stopped source holds its level, so edges only come while run is high
  always @(negedge clock) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) lvl_q <= ~lvl_q;
    end
  end
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the selectable odd clock divider
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import odd_div_pkg::*;
  localparam int HALF = 8;  // in_clk half period in clocks
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic enable = 1'b1;
  logic async_clear_n = 1'b1;
  logic ratio_sel = 1'b1;
  logic run = 1'b0;
  logic in_clk;
  logic out_clk;
  logic out_clk_n;
  int   bad_count = 0;
  int   num_checks = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  in_clk_src #(.HALF(HALF)) src (.clock(clock), .run(run), .in_clk(in_clk));
  selectable_odd_clock_divider dut (.clock(clock), .sys_rst(sys_rst), .in_clk(in_clk),
    .enable(enable), .async_clear_n(async_clear_n), .ratio_sel(ratio_sel),
    .out_clk(out_clk), .out_clk_n(out_clk_n));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // count cycles at level lvl, then stop at the change; bounded so a stuck output ends the run
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (out_clk === lvl) begin
      @(negedge clock);
      n++;
      if (n > 2000) begin
        bad_count++;
        complete_run();
      end
    end
  endtask

  task automatic test_ratio(input logic sel, input int ratio);
    int h;
    int l;
    ratio_sel = sel;
    repeat (3) begin
      run_len(1'b0, h);
      run_len(1'b1, h);
    end
    run_len(1'b0, l);
    run_len(1'b1, h);
    chk(h, ratio * HALF);
    chk(h + l, 2 * ratio * HALF);
    $display("ratio %0d done", ratio);
  endtask

  task automatic test_clear();
    int n;
    logic last;
    @(negedge clock);
    async_clear_n = 1'b0;
    #1 chk({out_clk, out_clk_n}, 2'b01);
    run = 1'b0;
    repeat (20) @(negedge clock);
    chk({out_clk, out_clk_n}, 2'b01);
    async_clear_n = 1'b1;
    repeat (10) @(negedge clock);
    run = 1'b1;
    n = 0;
    last = in_clk;
    // count input edges until the first output rise after the clear
    for (int i = 0; i < 2000 && out_clk !== 1'b1; i++) begin
      @(negedge clock);
      if (in_clk !== last) n++;
      last = in_clk;
    end
    if (out_clk !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    chk(n, RATIO_HI_DEF);
    $display("clear done");
  endtask

  task automatic test_disable();
    int h;
    int bad;
    run_len(1'b1, h);
    run_len(1'b0, h);
    enable = 1'b0;
    run_len(1'b1, h);
    chk(h, 5 * HALF);
    bad = 0;
    repeat (40 * HALF) begin
      @(negedge clock);
      if ({out_clk, out_clk_n} !== 2'b01) bad++;
    end
    chk(bad, 0);
    enable = 1'b1;
    run_len(1'b0, h);
    run_len(1'b1, h);
    chk(h, 5 * HALF);
    $display("disable done");
  endtask

  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    run = 1'b1;
    test_ratio(1'b1, 5);
    test_ratio(1'b0, 3);
    test_ratio(1'b1, 5);
    test_clear();
    test_disable();
    complete_run();
  end
endmodule

`default_nettype wire
